// >>> core/ilsl_pkg.sv
// Shared constants of the internal RAM size limiter.
// Assumes an AXI4-Lite register bus and a single-cycle CPU core bus.
package ilsl_pkg;

  // Printed register offsets are register indices, byte address = 4 * index.
  localparam logic [15:0] SIZE_REG_INDEX = 16'h5326;
  localparam logic [15:0] GUARD_REG_INDEX = 16'h5328;
  localparam logic [19:0] SIZE_REG_ADDR = {2'h0, SIZE_REG_INDEX, 2'h0};
  localparam logic [19:0] GUARD_REG_ADDR = {2'h0, GUARD_REG_INDEX, 2'h0};

  localparam logic [7:0] UNLOCK_KEY = 8'h96;
  localparam logic [7:0] GUARD_RESET = 8'h00;

  // Size field codes and reserved field contents.
  localparam logic [2:0] SIZE_2K = 3'h3;
  localparam logic [2:0] SIZE_4K = 3'h2;
  localparam logic [2:0] SIZE_8K = 3'h1;
  localparam logic [2:0] RESV_LARGE = 3'h1;
  localparam logic [2:0] RESV_SMALL = 3'h2;
  localparam int SIZE_LSB = 0;
  localparam int SIZE_MSB = 2;
  localparam int RESV_LSB = 4;
  localparam int RESV_MSB = 6;
  localparam int DBSEL_BIT = 8;

  // Variants: 8 KB, 4 KB resizable, 4 KB fixed, 2 KB fixed.
  localparam logic [1:0] VAR_8K = 2'h0;
  localparam logic [1:0] VAR_4K_SEL = 2'h1;
  localparam logic [1:0] VAR_4K_FIX = 2'h2;
  localparam logic [1:0] VAR_2K = 2'h3;

  // RAM geometry in 16-bit words.
  localparam int RAM_WORDS = 4096;
  localparam int RAM_AW = 12;
  localparam logic [12:0] WORDS_2K = 13'h0400;
  localparam logic [12:0] WORDS_4K = 13'h0800;
  localparam logic [12:0] WORDS_8K = 13'h1000;

  localparam logic [23:0] DBG_BASE_LOW = 24'h000000;
  localparam logic [23:0] DBG_BASE_HIGH = 24'hFFFC00;

  // Address map of the core bus.
  localparam logic [23:0] RAM_END = 24'h002000;
  localparam logic [23:0] DISP_BASE = 24'h0053C0;
  localparam logic [23:0] DISP_BYTES_WIDE = 24'h000038;
  localparam logic [23:0] DISP_BYTES_NARROW = 24'h000028;
  localparam int DISP_WORDS = 28;
  localparam int DISP_AW = 5;
  localparam logic [23:0] PERIPH1_BASE = 24'h004000;
  localparam logic [23:0] PERIPH1_END = 24'h004400;
  localparam logic [23:0] PERIPH2_BASE = 24'h005000;
  localparam logic [23:0] PERIPH2_END = 24'h006000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> core/ilsl_word_ram.sv
// Word-wide storage array with byte enables and combinational read.
// Assumes the caller registers the read data; out-of-range addresses read zero and are not written.
`timescale 1ns/1ns
`default_nettype none
module ilsl_word_ram #(
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [1:0] be,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);

  logic [15:0] mem [DEPTH];

  // The array holds no reset, so contents are undefined after power-up.
  always_ff @(posedge aclk) begin
    if (we && (int'(addr) < DEPTH)) begin
      if (be[0]) begin
        mem[addr][7:0] <= wdata[7:0];
      end
      if (be[1]) begin
        mem[addr][15:8] <= wdata[15:8];
      end
    end
  end

  always_comb begin
    if (int'(addr) < DEPTH) begin
      rdata = mem[addr];
    end else begin
      rdata = 16'h0000;
    end
  end

endmodule // ilsl_word_ram
`default_nettype wire

// >>> core/ilsl_top.sv
// Internal RAM with size limit, display RAM and core bus address decode.
// Assumes the CPU core bus and AXI4-Lite share aclk and aresetn.
// Function
// - Every RAM read or write, data or fetch, completes in one cycle.
// - RAM is mapped from zero: 8 KB, 4 KB or 2 KB per variant.
// - Size field bits 2..0: 3 is 2 KB, 2 is 4 KB, 1 is 8 KB.
// - Size field resets to 1 on 8 KB variant, 2 on smallest two.
// - Debug base select bit 8: 1 gives base 0, 0 gives 0xFFFC00.
// - Reserved bits read zero; bits 6..4 read 1 or 2 per variant.
// - Size register writes are ignored unless the guard holds the key.
// - Display RAM at 0x53C0, 56 or 40 bytes, one-cycle 16-bit access.
// - Display RAM serves as ordinary storage when not displaying.
// - Peripheral windows decode 1 KB at 0x4000 and 4 KB at 0x5000.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module ilsl_top #(
  parameter logic [1:0] VARIANT = 2'h0,
  parameter logic WIDE_DISPLAY = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [19:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [19:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_valid,
  input wire logic cpu_write,
  input wire logic [23:0] cpu_addr,
  input wire logic [1:0] cpu_be,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  output logic cpu_ready,
  output logic cpu_outside,
  output logic cpu_periph1_sel,
  output logic cpu_periph2_sel,
  output logic [23:0] debug_base
);

  localparam logic SMALL_VARIANT =
    (VARIANT == ilsl_pkg::VAR_4K_FIX) || (VARIANT == ilsl_pkg::VAR_2K);
  localparam logic [2:0] SIZE_RESET =
    SMALL_VARIANT ? ilsl_pkg::SIZE_4K : ilsl_pkg::SIZE_8K;
  localparam logic [2:0] RESV_VALUE =
    SMALL_VARIANT ? ilsl_pkg::RESV_SMALL : ilsl_pkg::RESV_LARGE;
  localparam logic [12:0] CAP_WORDS =
    (VARIANT == ilsl_pkg::VAR_8K) ? ilsl_pkg::WORDS_8K :
    (VARIANT == ilsl_pkg::VAR_2K) ? ilsl_pkg::WORDS_2K : ilsl_pkg::WORDS_4K;
  localparam logic [23:0] DISP_BYTES =
    WIDE_DISPLAY ? ilsl_pkg::DISP_BYTES_WIDE : ilsl_pkg::DISP_BYTES_NARROW;

  logic [2:0] ram_size_field_q;
  logic debug_base_sel_q;
  logic [7:0] config_write_guard_q;
  logic aw_have_q;
  logic [19:0] aw_addr_q;
  logic w_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [15:0] cpu_rdata_q;
  logic cpu_ready_q;
  logic cpu_outside_q;
  logic periph1_q;
  logic periph2_q;
  logic [23:0] debug_base_q;
  logic [12:0] limit_words;
  logic [15:0] size_reg_view;
  logic do_write;
  logic in_ram_span;
  logic in_ram_limit;
  logic in_disp;
  logic [23:0] disp_offset;
  logic [15:0] ram_rdata;
  logic [15:0] disp_rdata;

  // Usable size from the field; reserved codes fall back to full capacity.
  always_comb begin
    case (ram_size_field_q)
      ilsl_pkg::SIZE_2K: limit_words = ilsl_pkg::WORDS_2K;
      ilsl_pkg::SIZE_4K: limit_words = ilsl_pkg::WORDS_4K;
      ilsl_pkg::SIZE_8K: limit_words = ilsl_pkg::WORDS_8K;
      default: limit_words = CAP_WORDS;
    endcase
    if (limit_words > CAP_WORDS) begin
      limit_words = CAP_WORDS;
    end
  end

  always_comb begin
    size_reg_view = 16'h0000;
    size_reg_view[ilsl_pkg::SIZE_MSB:ilsl_pkg::SIZE_LSB] = ram_size_field_q;
    size_reg_view[ilsl_pkg::RESV_MSB:ilsl_pkg::RESV_LSB] = RESV_VALUE;
    size_reg_view[ilsl_pkg::DBSEL_BIT] = debug_base_sel_q;
  end

  // Core bus decode. The span covers the whole 8 KB so that accesses past
  // the selected size are caught instead of aliasing onto low RAM.
  always_comb begin
    in_ram_span = cpu_addr < ilsl_pkg::RAM_END;
    in_ram_limit = in_ram_span &&
      ({1'b0, cpu_addr[12:1]} < limit_words);
    disp_offset = cpu_addr - ilsl_pkg::DISP_BASE;
    in_disp = (cpu_addr >= ilsl_pkg::DISP_BASE) &&
      (disp_offset < DISP_BYTES);
  end

  ilsl_word_ram #(
    .DEPTH(ilsl_pkg::RAM_WORDS),
    .AW(ilsl_pkg::RAM_AW)
  ) u_main_ram (
    .aclk(aclk),
    .we(cpu_valid && cpu_write && in_ram_limit),
    .be(cpu_be),
    .addr(cpu_addr[12:1]),
    .wdata(cpu_wdata),
    .rdata(ram_rdata)
  );

  // The display array is plain storage; the LCD side is not modelled here.
  ilsl_word_ram #(
    .DEPTH(ilsl_pkg::DISP_WORDS),
    .AW(ilsl_pkg::DISP_AW)
  ) u_disp_ram (
    .aclk(aclk),
    .we(cpu_valid && cpu_write && in_disp),
    .be(cpu_be),
    .addr(disp_offset[5:1]),
    .wdata(cpu_wdata),
    .rdata(disp_rdata)
  );

  // Every RAM or display access is answered at the next edge with no wait state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_ready_q <= 1'b0;
      cpu_rdata_q <= 16'h0000;
      cpu_outside_q <= 1'b0;
    end else begin
      cpu_ready_q <= cpu_valid && (in_ram_limit || in_disp);
      cpu_outside_q <= cpu_valid && in_ram_span && !in_ram_limit;
      if (cpu_valid && !cpu_write && in_ram_limit) begin
        cpu_rdata_q <= ram_rdata;
      end else if (cpu_valid && !cpu_write && in_disp) begin
        cpu_rdata_q <= disp_rdata;
      end else begin
        cpu_rdata_q <= 16'h0000;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph1_q <= 1'b0;
      periph2_q <= 1'b0;
    end else begin
      periph1_q <= cpu_valid && (cpu_addr >= ilsl_pkg::PERIPH1_BASE) &&
        (cpu_addr < ilsl_pkg::PERIPH1_END);
      periph2_q <= cpu_valid && (cpu_addr >= ilsl_pkg::PERIPH2_BASE) &&
        (cpu_addr < ilsl_pkg::PERIPH2_END);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      debug_base_q <= ilsl_pkg::DBG_BASE_HIGH;
    end else if (debug_base_sel_q) begin
      debug_base_q <= ilsl_pkg::DBG_BASE_LOW;
    end else begin
      debug_base_q <= ilsl_pkg::DBG_BASE_HIGH;
    end
  end

  // AXI write side: address and data are taken in either order.
  assign do_write = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b0;
      aw_addr_q <= 20'h00000;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (bvalid_q && s_axi_bready) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (bvalid_q && s_axi_bready) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= ilsl_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      if ((aw_addr_q == ilsl_pkg::SIZE_REG_ADDR) ||
          (aw_addr_q == ilsl_pkg::GUARD_REG_ADDR)) begin
        bresp_q <= ilsl_pkg::RESP_OKAY;
      end else begin
        bresp_q <= ilsl_pkg::RESP_SLVERR;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // A locked write still answers OKAY; only the contents stay unchanged.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_size_field_q <= SIZE_RESET;
      debug_base_sel_q <= 1'b0;
    end else if (do_write && (aw_addr_q == ilsl_pkg::SIZE_REG_ADDR) &&
                 (config_write_guard_q == ilsl_pkg::UNLOCK_KEY)) begin
      if (w_strb_q[0]) begin
        ram_size_field_q <=
          w_data_q[ilsl_pkg::SIZE_MSB:ilsl_pkg::SIZE_LSB];
      end
      if (w_strb_q[1]) begin
        debug_base_sel_q <= w_data_q[ilsl_pkg::DBSEL_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_write_guard_q <= ilsl_pkg::GUARD_RESET;
    end else if (do_write && (aw_addr_q == ilsl_pkg::GUARD_REG_ADDR) &&
                 w_strb_q[0]) begin
      config_write_guard_q <= w_data_q[7:0];
    end
  end

  // AXI read side: one read at a time, answered one cycle after the arvalid and arready handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= ilsl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      if (s_axi_araddr == ilsl_pkg::SIZE_REG_ADDR) begin
        rdata_q <= {16'h0000, size_reg_view};
        rresp_q <= ilsl_pkg::RESP_OKAY;
      end else if (s_axi_araddr == ilsl_pkg::GUARD_REG_ADDR) begin
        rdata_q <= {24'h000000, config_write_guard_q};
        rresp_q <= ilsl_pkg::RESP_OKAY;
      end else begin
        rdata_q <= 32'h00000000;
        rresp_q <= ilsl_pkg::RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign cpu_rdata = cpu_rdata_q;
  assign cpu_ready = cpu_ready_q;
  assign cpu_outside = cpu_outside_q;
  assign cpu_periph1_sel = periph1_q;
  assign cpu_periph2_sel = periph2_q;
  assign debug_base = debug_base_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ONE_CYCLE: assert property (
    cpu_valid && in_ram_limit |=> cpu_ready && !cpu_outside)
    else $error("RAM access did not finish in one cycle");

  AST_SIZE_DECODE: assert property (
    ram_size_field_q == ilsl_pkg::SIZE_2K |-> limit_words == 13'h0400)
    else $error("2 KB code did not limit the RAM");

  AST_RESET_SIZE: assert property (
    $rose(aresetn) |-> ram_size_field_q == SIZE_RESET)
    else $error("Size field reset value wrong");

  AST_DEBUG_BASE: assert property (
    debug_base_sel_q ##1 debug_base_sel_q |-> debug_base == 24'h000000)
    else $error("Debug base did not follow the select bit");

  AST_RESV_READ: assert property (
    s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == ilsl_pkg::SIZE_REG_ADDR |=>
    s_axi_rvalid && s_axi_rdata[31:9] == 23'h0 && !s_axi_rdata[7] &&
    !s_axi_rdata[3] && s_axi_rdata[6:4] == RESV_VALUE)
    else $error("Reserved size register bits read wrong");

  AST_LOCKED: assert property (
    do_write && aw_addr_q == ilsl_pkg::SIZE_REG_ADDR &&
    config_write_guard_q != ilsl_pkg::UNLOCK_KEY |=>
    $stable(ram_size_field_q) && $stable(debug_base_sel_q))
    else $error("Locked size register changed");

  AST_UNLOCKED: assert property (
    do_write && aw_addr_q == ilsl_pkg::SIZE_REG_ADDR && w_strb_q[0] &&
    config_write_guard_q == ilsl_pkg::UNLOCK_KEY |=>
    ram_size_field_q == $past(w_data_q[2:0]))
    else $error("Unlocked size write not stored");

  AST_DISPLAY: assert property (
    cpu_valid && cpu_addr == 24'h0053C0 |=> cpu_ready && !cpu_outside)
    else $error("Display RAM not answered in one cycle");

  AST_PERIPH: assert property (
    cpu_valid && cpu_addr[23:10] == 14'h0010 |=> cpu_periph1_sel)
    else $error("Peripheral window 1 not decoded");

  AST_OUTSIDE: assert property (
    cpu_valid && cpu_addr < 24'h002000 &&
    {1'b0, cpu_addr[12:1]} >= limit_words |=> cpu_outside && !cpu_ready)
    else $error("Access past the size limit not flagged");

  COV_UNLOCK_WRITE: cover property (
    do_write && aw_addr_q == ilsl_pkg::SIZE_REG_ADDR &&
    config_write_guard_q == ilsl_pkg::UNLOCK_KEY);
  COV_OUTSIDE: cover property (cpu_outside);
  COV_DISP_WRITE: cover property (cpu_valid && cpu_write && in_disp);

endmodule // ilsl_top
`default_nettype wire

// >>> tb/ilsl_cpu_model.sv
// Core bus master model standing in for the CPU in the RAM limiter bench.
// Assumes the bench calls req once per cycle and idle after each burst.
`timescale 1ns/1ns
`default_nettype none
module ilsl_cpu_model (
  input wire logic aclk,
  output logic cpu_valid,
  output logic cpu_write,
  output logic [23:0] cpu_addr,
  output logic [1:0] cpu_be,
  output logic [15:0] cpu_wdata
);
  initial begin
    cpu_valid = 1'b0;
    cpu_write = 1'b0;
    cpu_addr = 24'h000000;
    cpu_be = 2'h0;
    cpu_wdata = 16'h0000;
  end

  // One request per cycle, launched just after the edge.
  task automatic req(input logic w, input logic [23:0] a,
                     input logic [1:0] be, input logic [15:0] d);
    @(posedge aclk);
    cpu_valid <= 1'b1;
    cpu_write <= w;
    cpu_addr <= a;
    cpu_be <= be;
    cpu_wdata <= d;
  endtask

  // Released lines are inverted so a stale request never looks valid.
  task automatic idle();
    @(posedge aclk);
    cpu_valid <= 1'b0;
    cpu_addr <= ~cpu_addr;
    cpu_wdata <= ~cpu_wdata;
  endtask
endmodule // ilsl_cpu_model
`default_nettype wire

// >>> tb/tb_ilsl_top.sv
// Self-checking bench of the RAM size limiter over AXI-Lite and core bus.
// Assumes the 8 KB variant with the wide display RAM, plus a 2 KB one.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_ilsl_top;
  localparam logic [19:0] SZ = ilsl_pkg::SIZE_REG_ADDR;
  localparam logic [19:0] GD = ilsl_pkg::GUARD_REG_ADDR;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [19:0] s_axi_awaddr = 20'h00000, s_axi_araddr = 20'h00000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_valid, cpu_write, cpu_ready, cpu_outside;
  logic cpu_periph1_sel, cpu_periph2_sel;
  logic [1:0] s_axi_bresp, s_axi_rresp, cpu_be;
  logic [31:0] s_axi_rdata, r;
  logic [23:0] cpu_addr, debug_base, lim = 24'h002000, a;
  logic [15:0] cpu_wdata, cpu_rdata;
  logic [31:0] small_rdata;
  logic [23:0] small_debug_base;
  logic [15:0] mem[int];
  logic [33:0] qa[$];
  logic [19:0] qc[$];
  logic [2:0] codes[4] = '{3'h3, 3'h2, 3'h7, 3'h1};
  logic v1 = 1'b0;
  int fails = 0, checked = 0, seed = 38, cycles = 0;

  always #25 aclk = ~aclk;

  ilsl_top #(.VARIANT(2'h0), .WIDE_DISPLAY(1'b1)) u_ilsl_top (.aclk,
    .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_valid,
    .cpu_write, .cpu_addr, .cpu_be, .cpu_wdata, .cpu_rdata, .cpu_ready,
    .cpu_outside, .cpu_periph1_sel, .cpu_periph2_sel, .debug_base);
  ilsl_cpu_model u_ilsl_cpu_model (.aclk, .cpu_valid, .cpu_write,
    .cpu_addr, .cpu_be, .cpu_wdata);
  // The small variant is only read, so its size field is never changed.
  ilsl_top #(.VARIANT(ilsl_pkg::VAR_2K), .WIDE_DISPLAY(1'b0))
    u_ilsl_top_small (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid(1'b0), .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid(1'b0), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(),
    .s_axi_rdata(small_rdata), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready, .cpu_valid, .cpu_write, .cpu_addr, .cpu_be, .cpu_wdata,
    .cpu_rdata(), .cpu_ready(), .cpu_outside(), .cpu_periph1_sel(),
    .cpu_periph2_sel(), .debug_base(small_debug_base));

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  // Results are compared in the order their requests were issued.
  always @(posedge aclk) begin
    logic [33:0] ea;
    logic [19:0] ec, got;
    if (s_axi_bvalid && s_axi_bready) begin
      ea = qa.pop_front();
      `CHK({s_axi_bresp, 32'h0}, ea)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      ea = qa.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, ea)
    end
    if (v1) begin
      ec = qc.pop_front();
      got = {cpu_ready, cpu_outside, cpu_periph1_sel, cpu_periph2_sel,
        cpu_rdata};
      `CHK(got, ec)
    end
    v1 <= cpu_valid;
  end

  task automatic axw(input logic [19:0] ad, input logic [31:0] d,
                     input logic [1:0] rs);
    qa.push_back({rs, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axr(input logic [19:0] ad, input logic [33:0] e);
    qa.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic cpu(input logic w, input logic [23:0] ad,
                     input logic [1:0] be, input logic [15:0] d);
    logic ram, hit;
    int k;
    k = int'(ad[23:1]);
    ram = ad < lim;
    hit = ram || (ad >= 24'h0053C0 && ad < 24'h0053F8);
    if (w && hit && be[0]) mem[k][7:0] = d[7:0];
    if (w && hit && be[1]) mem[k][15:8] = d[15:8];
    qc.push_back({hit, ad < 24'h002000 && !ram,
      ad >= 24'h004000 && ad < 24'h004400,
      ad >= 24'h005000 && ad < 24'h006000,
      (!w && hit) ? mem[k] : 16'h0000});
    u_ilsl_cpu_model.req(w, ad, be, d);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(debug_base, 24'hFFFC00)
    axr(SZ, {2'h0, 32'h0000_0011});
    `CHK(small_rdata, 32'h0000_0022)
    `CHK(small_debug_base, 24'hFFFC00)
    axr(GD, {2'h0, 32'h0});
    axr(20'h00100, {2'h2, 32'h0});
    axw(20'h00100, 32'h1, 2'h2);
    axw(SZ, 32'h0000_0103, 2'h0);
    axr(SZ, {2'h0, 32'h0000_0011});
    $display("test register reset and lock done");
    cpu(1'b1, 24'h001800, 2'h3, 16'hA55A);
    // Random traffic stays below the debugger's top 128 bytes.
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      a = r[23:0] & 24'h001F7E;
      cpu(1'b1, a, 2'h3, r[31:16]);
      cpu(1'b0, a, 2'h3, r[15:0]);
      cpu(1'b1, a, {1'b0, r[0]} + 2'h1, ~r[15:0]);
      cpu(1'b0, a, 2'h3, r[31:16]);
    end
    u_ilsl_cpu_model.idle();
    $display("test ram traffic done");
    for (int i = 0; i < 4; i++) begin
      axw(GD, {24'h0, ilsl_pkg::UNLOCK_KEY}, 2'h0);
      axw(SZ, {23'h7FFFFF, i[0], 5'h1F, codes[i]}, 2'h0);
      axw(GD, 32'h0, 2'h0);
      axr(SZ, {2'h0, 23'h0, i[0], 5'h02, codes[i]});
      `CHK(debug_base, i[0] ? 24'h000000 : 24'hFFFC00)
      lim = codes[i] == 3'h3 ? 24'h000800 :
            codes[i] == 3'h2 ? 24'h001000 : 24'h002000;
      cpu(1'b1, lim - 24'h2, 2'h3, 16'h5AA5);
      cpu(1'b0, lim - 24'h2, 2'h3, 16'h0);
      cpu(1'b1, lim, 2'h3, 16'hDEAD);
      cpu(1'b0, lim, 2'h3, 16'h0);
      cpu(1'b0, 24'h001800, 2'h3, 16'h0);
      u_ilsl_cpu_model.idle();
    end
    $display("test size codes done");
    for (int i = 0; i < 28; i++) begin
      r = $random(seed);
      cpu(1'b1, 24'h0053C0 + 24'(2 * i), 2'h3, r[15:0]);
    end
    for (int i = 0; i < 29; i++) cpu(1'b0, 24'h0053C0 + 24'(2 * i), 2'h3,
      16'h0);
    foreach (codes[i]) cpu(1'b0, 24'h003FFE + 24'(i * 24'h400), 2'h3,
      16'h0);
    cpu(1'b0, 24'h005000, 2'h3, 16'h0);
    cpu(1'b0, 24'h005FFE, 2'h3, 16'h0);
    cpu(1'b0, 24'h006000, 2'h3, 16'h0);
    u_ilsl_cpu_model.idle();
    repeat (4) @(posedge aclk);
    $display("test display and windows done");
    conclude();
  end
endmodule // tb_ilsl_top
`default_nettype wire
